// >>> hw/cfw_consts.vh
`ifndef CFW_CONSTS_VH
`define CFW_CONSTS_VH
// byte addresses of the two configuration bytes
`define CFW_ADDR_LOW          22'h300000
`define CFW_ADDR_HIGH         22'h300001
`define CFW_ADDR_W            22
// field positions, low byte
`define CFW_BIT_WDT_HARD      0
`define CFW_BIT_STACK_RST     5
`define CFW_BIT_EXT_INSTR     6
`define CFW_BIT_DEBUG         7
// field positions, high byte
`define CFW_BIT_CODE_PROT     2
// implemented-bit masks and unprogrammed (erased) values
`define CFW_LOW_MASK          8'hE1
`define CFW_HIGH_MASK         8'h04
`define CFW_LOW_ERASED        8'hE1
`define CFW_HIGH_ERASED       8'h04
// pattern for the unimplemented upper bits 7..3 of the high byte; unused, those bits hold zero
`define CFW_HIGH_KEEP         5'h1E
`endif

// >>> hw/cfw_config_word.v
// Summary of operation
// - low bit0 set forces watchdog; else software
// - low bit5 enables stack fault reset
// - high bit2 zero means code protected
// - low byte 300000h, high byte 300001h
//
// The plain strobed port was chosen for this implementation.
`include "cfw_consts.vh"

module cfw_config_word (
   input  wire                     ref_clk_i,
   input  wire                     rst_i,
   input  wire                     clk_en_i,
   input  wire [`CFW_ADDR_W-1:0]   addr_i,
   input  wire [7:0]               wdata_i,
   input  wire                     wr_i,
   input  wire                     rd_i,
   input  wire                     watchdog_soft_enable_i,
   output reg  [7:0]               rdata_o,
   output reg                      watchdog_run_o,
   output reg                      watchdog_hard_enable_o,
   output reg                      stack_fault_reset_enable_o,
   output reg                      extended_instr_enable_o,
   output reg                      code_protect_o
);

   // erased values as constants, so single bits can be picked out
   localparam [7:0] low_erased  = `CFW_LOW_ERASED;
   localparam [7:0] high_erased = `CFW_HIGH_ERASED;

   // stored bytes and their next values
   reg  [7:0] config_word_low_q;
   reg  [7:0] config_word_low_d;
   reg  [7:0] config_word_high_q;
   reg  [7:0] config_word_high_d;

   // write-once locks, one flag per stored bit
   reg  [7:0] low_written_q;
   reg  [7:0] low_written_d;
   reg  [7:0] high_written_q;
   reg  [7:0] high_written_d;

   // read data, next value
   reg  [7:0] rdata_d;

   // decoded control levels, next values
   reg        watchdog_hard_enable_d;
   reg        watchdog_run_d;
   reg        stack_fault_reset_enable_d;
   reg        extended_instr_enable_d;
   reg        code_protect_d;

   // qualified bus strobes
   wire       hit_low;
   wire       hit_high;
   wire       wr_low;
   wire       wr_high;
   wire       rd_low;
   wire       rd_high;

   // exact byte address match; no aliases of the two bytes
   function cfw_addr_hit;
      input [`CFW_ADDR_W-1:0] addr;
      input [`CFW_ADDR_W-1:0] target;
      begin
         cfw_addr_hit = (addr == target);
      end
   endfunction

   // write-once merge: only implemented, not yet written bits take new data
   function [7:0] cfw_merge;
      input [7:0] cur;
      input [7:0] done;
      input [7:0] mask;
      input [7:0] data;
      reg   [7:0] open_bits;
      begin
         open_bits = mask & ~done;
         cfw_merge = (cur & ~open_bits) | (data & open_bits);
      end
   endfunction

   // any write burns the whole byte, zeros too, so no second try
   function [7:0] cfw_lock;
      input [7:0] done;
      input [7:0] mask;
      input       strobe;
      begin
         if (strobe) begin
            cfw_lock = done | mask;
         end else begin
            cfw_lock = done;
         end
      end
   endfunction

   // visible value: unimplemented bits read as zero
   function [7:0] cfw_visible;
      input [7:0] cur;
      input [7:0] mask;
      begin
         cfw_visible = cur & mask;
      end
   endfunction

   // address decode
   assign hit_low  = cfw_addr_hit(addr_i, `CFW_ADDR_LOW);
   assign hit_high = cfw_addr_hit(addr_i, `CFW_ADDR_HIGH);

   // strobes qualified by address; unmapped traffic is dropped
   assign wr_low  = wr_i & hit_low;
   assign wr_high = wr_i & hit_high;
   assign rd_low  = rd_i & hit_low;
   assign rd_high = rd_i & hit_high;

   // low byte next value
   always @* begin
      config_word_low_d = config_word_low_q;
      if (wr_low) begin
         config_word_low_d = cfw_merge(config_word_low_q, low_written_q,
                                       `CFW_LOW_MASK, wdata_i);
      end
   end

   // high byte next value; only bit 2 takes write data, bits 7..3 stay at erased zero
   always @* begin
      config_word_high_d = config_word_high_q;
      if (wr_high) begin
         config_word_high_d = cfw_merge(config_word_high_q, high_written_q,
                                        `CFW_HIGH_MASK, wdata_i);
      end
   end

   // lock next values
   always @* begin
      low_written_d  = cfw_lock(low_written_q, `CFW_LOW_MASK, wr_low);
      high_written_d = cfw_lock(high_written_q, `CFW_HIGH_MASK, wr_high);
   end

   // read mux; idle cycles give zero, so data stands one cycle only
   always @* begin
      rdata_d = 8'h00;
      if (rd_low) begin
         rdata_d = cfw_visible(config_word_low_q, `CFW_LOW_MASK);
      end else if (rd_high) begin
         rdata_d = cfw_visible(config_word_high_q, `CFW_HIGH_MASK);
      end
   end

   // decoded levels from the stored bytes
   always @* begin
      watchdog_hard_enable_d     = config_word_low_q[`CFW_BIT_WDT_HARD];
      watchdog_run_d             = config_word_low_q[`CFW_BIT_WDT_HARD]
                                   | watchdog_soft_enable_i;
      stack_fault_reset_enable_d = config_word_low_q[`CFW_BIT_STACK_RST];
      extended_instr_enable_d    = config_word_low_q[`CFW_BIT_EXT_INSTR];
      code_protect_d             = ~config_word_high_q[`CFW_BIT_CODE_PROT];
   end

   // low byte storage; reset stands in for power-on, back to erased
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         config_word_low_q <= `CFW_LOW_ERASED;
      end else if (clk_en_i) begin
         config_word_low_q <= config_word_low_d;
      end
   end

   // high byte storage
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         config_word_high_q <= `CFW_HIGH_ERASED;
      end else if (clk_en_i) begin
         config_word_high_q <= config_word_high_d;
      end
   end

   // low byte lock; reset reopens it as power-on would
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         low_written_q <= 8'h00;
      end else if (clk_en_i) begin
         low_written_q <= low_written_d;
      end
   end

   // high byte lock
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         high_written_q <= 8'h00;
      end else if (clk_en_i) begin
         high_written_q <= high_written_d;
      end
   end

   // read data register; frozen with everything else
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         rdata_o <= rdata_d;
      end
   end

   // hardware watchdog enable
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         watchdog_hard_enable_o <= low_erased[`CFW_BIT_WDT_HARD];
      end else if (clk_en_i) begin
         watchdog_hard_enable_o <= watchdog_hard_enable_d;
      end
   end

   // watchdog run; soft request taken as synchronous, one cycle late
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         watchdog_run_o <= low_erased[`CFW_BIT_WDT_HARD];
      end else if (clk_en_i) begin
         watchdog_run_o <= watchdog_run_d;
      end
   end

   // stack fault reset enable
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         stack_fault_reset_enable_o <= low_erased[`CFW_BIT_STACK_RST];
      end else if (clk_en_i) begin
         stack_fault_reset_enable_o <= stack_fault_reset_enable_d;
      end
   end

   // extended instruction set enable
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         extended_instr_enable_o <= low_erased[`CFW_BIT_EXT_INSTR];
      end else if (clk_en_i) begin
         extended_instr_enable_o <= extended_instr_enable_d;
      end
   end

   // code protection, high means protected
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         code_protect_o <= ~high_erased[`CFW_BIT_CODE_PROT];
      end else if (clk_en_i) begin
         code_protect_o <= code_protect_d;
      end
   end

endmodule // cfw_config_word

// >>> sim/cfw_config_sva.sv
module cfw_config_sva (
   input wire        ref_clk_i,
   input wire        rst_i,
   input wire        clk_en_i,
   input wire [21:0] addr_i,
   input wire [7:0]  wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire        watchdog_soft_enable_i,
   input wire [7:0]  rdata_o,
   input wire        watchdog_run_o,
   input wire        watchdog_hard_enable_o,
   input wire        stack_fault_reset_enable_o,
   input wire        extended_instr_enable_o,
   input wire        code_protect_o
);
   timeunit 1ns;
   timeprecision 1ns;
   reg  lo_q;
   reg  hi_q;
   // accepted writes only; a frozen clock enable takes nothing
   wire fl = wr_i & clk_en_i & addr_i == 22'h300000 & !lo_q;
   wire fh = wr_i & clk_en_i & addr_i == 22'h300001 & !hi_q;
   // first write per byte; reset reopens
   always @(posedge ref_clk_i) begin
      lo_q <= !rst_i & (lo_q | fl);
      hi_q <= !rst_i & (hi_q | fh);
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_hard_load: assert property (fl ##1 clk_en_i |=>
      watchdog_hard_enable_o == $past(wdata_i[0], 2)) else $error("wdt");
   a_stack_load: assert property (fl ##1 clk_en_i |=>
      stack_fault_reset_enable_o == $past(wdata_i[5], 2)) else $error("stack");
   a_ext_load: assert property (fl ##1 clk_en_i |=>
      extended_instr_enable_o == $past(wdata_i[6], 2)) else $error("ext");
   a_prot_load: assert property (fh ##1 clk_en_i |=>
      code_protect_o != $past(wdata_i[2], 2)) else $error("prot");
   a_unmapped_read: assert property (rd_i & clk_en_i & addr_i[21:1] != 21'h180000
      |=> rdata_o == 8'h00) else $error("unmapped");
   a_run_combine: assert property (clk_en_i |=>
      watchdog_run_o == (watchdog_hard_enable_o | $past(watchdog_soft_enable_i)))
      else $error("run");
   a_high_mask: assert property (rd_i & clk_en_i & addr_i == 22'h300001 |=>
      (rdata_o & 8'hFB) == 8'h00) else $error("high mask");
   a_write_once: assert property (lo_q & $past(lo_q)
      |=> $stable(stack_fault_reset_enable_o)) else $error("relock");
   cover property (fl);
   cover property (fh);
   cover property (rd_i & addr_i == 22'h300001);
   cover property (wr_i & !clk_en_i);
endmodule // cfw_config_sva
bind cfw_config_word cfw_config_sva chk_u (.*);

// >>> sim/test_config_fuse_word_low_high.sv
module test_config_fuse_word_low_high;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0;
   logic watchdog_soft_enable_i = 1'h0, clk_en_i = 1'h1;
   logic [21:0] addr_i = 22'h0;
   logic [7:0] wdata_i = 8'h0;
   wire [7:0] rdata_o;
   wire watchdog_run_o, watchdog_hard_enable_o, stack_fault_reset_enable_o;
   wire extended_instr_enable_o, code_protect_o;
   wire [7:0] dec = {3'h0, watchdog_hard_enable_o, stack_fault_reset_enable_o,
                     extended_instr_enable_o, code_protect_o, watchdog_run_o};
   int err_count = 0, total_checks = 0, cyc = 0;
   logic [29:0] rows [3] = '{{22'h300000, 8'hE1}, {22'h300001, 8'h04}, {22'h3FFFFF, 8'h00}};
   cfw_config_word dut_u (
      .ref_clk_i                  (ref_clk_i),
      .rst_i                      (rst_i),
      .clk_en_i                   (clk_en_i),
      .addr_i                     (addr_i),
      .wdata_i                    (wdata_i),
      .wr_i                       (wr_i),
      .rd_i                       (rd_i),
      .watchdog_soft_enable_i     (watchdog_soft_enable_i),
      .rdata_o                    (rdata_o),
      .watchdog_run_o             (watchdog_run_o),
      .watchdog_hard_enable_o     (watchdog_hard_enable_o),
      .stack_fault_reset_enable_o (stack_fault_reset_enable_o),
      .extended_instr_enable_o    (extended_instr_enable_o),
      .code_protect_o             (code_protect_o)
   );
   always #25 ref_clk_i = ~ref_clk_i;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one bus cycle; for reads d is the expected data
   task automatic bus(input logic w, input logic [21:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= w;
      rd_i <= !w;
      @(posedge ref_clk_i);
      wr_i <= 1'h0;
      rd_i <= 1'h0;
      #1;
      if (!w) chk(rdata_o, d);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, run needs well under 100 cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc > 300) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'h0;
      foreach (rows[i]) bus(1'h0, rows[i][29:8], rows[i][7:0]);
      bus(1'h1, 22'h300000, 8'h00);
      bus(1'h1, 22'h300001, 8'hF3);
      bus(1'h1, 22'h300000, 8'hFF);
      bus(1'h0, 22'h300000, 8'h00);
      bus(1'h0, 22'h300001, 8'h00);
      chk(dec, 8'h02);
      @(posedge ref_clk_i) watchdog_soft_enable_i <= 1'h1;
      repeat (2) @(posedge ref_clk_i);
      #1 chk(dec, 8'h03);
      @(posedge ref_clk_i) rst_i <= 1'h1;
      @(posedge ref_clk_i) rst_i <= 1'h0;
      #1 chk(dec, 8'h1D);
      // clock enable low: a write must leave the erased byte alone
      @(posedge ref_clk_i) clk_en_i <= 1'h0;
      bus(1'h1, 22'h300000, 8'h00);
      @(posedge ref_clk_i) clk_en_i <= 1'h1;
      bus(1'h0, 22'h300000, 8'hE1);
      // read data stands one cycle, then falls back to zero
      @(posedge ref_clk_i);
      #1 chk(rdata_o, 8'h00);
      // reset reopened the lock: one fresh write lands, the next does not
      bus(1'h1, 22'h300000, 8'h41);
      bus(1'h1, 22'h300000, 8'hA0);
      bus(1'h0, 22'h300000, 8'h41);
      bus(1'h0, 22'h300001, 8'h04);
      chk(dec, 8'h15);
      end_sim();
   end
endmodule // test_config_fuse_word_low_high
